// >>> hdl/irq_ctrl_pkg.sv
// package of constants for the interrupt flag and mask unit
package irq_ctrl_pkg;
    // register map of the interrupt control bit area and port select
    localparam logic [5:0] ADDR_WORD0     = 6'h00;
    localparam logic [5:0] ADDR_WORD1     = 6'h01;
    localparam logic [5:0] ADDR_WORD2     = 6'h02;
    localparam logic [5:0] ADDR_WORD3     = 6'h03;
    localparam logic [5:0] ADDR_PORT_SEL  = 6'h24;
    // bit positions inside each word
    localparam int unsigned BIT0          = 0;
    localparam int unsigned BIT1          = 1;
    localparam int unsigned BIT2          = 2;
    localparam int unsigned BIT3          = 3;
    // number of interrupt sources
    localparam int unsigned NUM_SRC       = 7;
    // source indices in priority order, highest first
    localparam int unsigned SRC_EXT0      = 0;
    localparam int unsigned SRC_EXT1      = 1;
    localparam int unsigned SRC_TMR_A     = 2;
    localparam int unsigned SRC_TMR_B     = 3;
    localparam int unsigned SRC_TMR_C     = 4;
    localparam int unsigned SRC_CONV      = 5;
    localparam int unsigned SRC_SERIAL    = 6;
    // vector addresses
    localparam logic [13:0] VEC_BASE      = 14'h0002;
    localparam logic [13:0] VEC_STEP      = 14'h0002;
    // stack pointer decrement on acceptance
    localparam logic [3:0] SP_DECREMENT   = 4'h4;
    // reset values
    localparam logic [3:0] PORT_SEL_RST   = 4'h0;
    localparam logic       MASK_RST       = 1'b1;
    localparam logic       FLAG_RST       = 1'b0;
    localparam logic       ENABLE_RST     = 1'b0;
endpackage : irq_ctrl_pkg

// >>> hdl/fall_edge_detect.sv
// falling edge detector with a two flip-flop synchroniser
`timescale 1ns/100ps
module fall_edge_detect (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin side
    input  wire logic pin_in,
    input  wire logic enable,
    // event out
    output logic      fall_pulse
);
    logic sync1_ff; // first stage, read only by sync2
    logic sync2_ff; // second stage
    logic prev_ff;  // delayed sample for comparison

    // synchroniser; idles high since the pin is active low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff  <= 1'b1;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // high then low on synced samples; gated by select so i/o use is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_pulse <= 1'b0;
        end else begin
            fall_pulse <= enable & prev_ff & ~sync2_ff;
        end
    end
endmodule // fall_edge_detect

// >>> hdl/interrupt_flag_mask_unit.sv
// interrupt enable, request flags, masks, priority and port select
// Overview of operation
// - event select routes pin to timer event
// - second pin select, cleared by reset/stop
// - first pin select, cleared by reset/stop
// - stop-clear select routes pin, reset or write clears
// - enable cleared on accept, set on return
// - enable bit-writable, resets to zero
// - falling edge on pin sets external flag
// - external flags cleared by writing zero or by stop
// - external flags survive acceptance
// - external accept needs flag, unmasked, enable
// - mask defers request; masks reset to one
// - timer overflow sets its timer flag
// - timer flags survive acceptance, zero clears
// - timer accept needs flag, unmasked, enable
// - serial completion or abort sets flag
// - serial flag cleared by zero write or by stop
// - serial accept needs flag, unmasked, enable
// - conversion done sets converter flag
// - converter flag survives accept, zero clears
// - converter accept needs flag, unmasked, enable
// - fixed priority with per-source vector address
// - accept at instruction end, push, sp minus four
`timescale 1ns/100ps
module interrupt_flag_mask_unit (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // low power control
    input  wire logic        stop_mode,
    // cpu bit access port
    input  wire logic [5:0]  bit_addr,
    input  wire logic [1:0]  bit_sel,
    input  wire logic        bit_wr,
    input  wire logic        bit_wdata,
    input  wire logic        port_sel_wr,
    input  wire logic [3:0]  port_sel_wdata,
    output logic [3:0]       rd_word,
    // cpu sequencer handshake
    input  wire logic        instr_done,
    input  wire logic        return_from_irq_instr,
    output logic             irq_take,
    output logic [13:0]      irq_vector,
    output logic [3:0]       sp_decrement,
    output logic             global_irq_enable,
    // peripheral events
    input  wire logic        tmr_a_ovf,
    input  wire logic        tmr_b_ovf,
    input  wire logic        tmr_c_ovf,
    input  wire logic        serial_done,
    input  wire logic        conv_done,
    // shared port pins
    input  wire logic        ext_irq0_pin,
    input  wire logic        ext_irq1_pin,
    input  wire logic        port_d_bit2,
    input  wire logic        port_d_bit4,
    // routed pin functions
    output logic             timer_event_in,
    output logic             stop_clear_in,
    output logic [3:0]       port_function_select_b
);
    logic                ie_ff;        // global enable
    wire  [6:0]          flag_ff;      // request flags by source, one flop per g_flag block
    wire  [6:0]          mask_ff;      // masks by source, one flop per g_flag block
    logic                ext0_fall;    // synced edge events
    logic                ext1_fall;
    logic [6:0]          set_evt;      // hardware set per source
    logic [6:0]          eligible;     // flag and not mask
    logic [6:0]          wr_clear;     // software zero writes
    logic [6:0]          wr_mask_en;   // mask write strobes
    logic [2:0]          win_idx;      // highest priority eligible
    logic                any_eligible;
    logic                accept;
    logic [1:0]          d2_sync_ff;   // routed pin synchronisers
    logic [1:0]          d4_sync_ff;
    logic [3:0]          nxt_rd;

    // bit address decode shared by flag and mask writes
    function automatic logic bit_hit(input logic [5:0] a, input logic [1:0] s,
                                     input logic [5:0] wa, input int unsigned wb);
        bit_hit = (a == wa) && (s == wb[1:0]);
    endfunction

    // external pin edge detectors, active only when routed
    fall_edge_detect u_ext0 (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_in     (ext_irq0_pin),
        .enable     (port_function_select_b[irq_ctrl_pkg::BIT0]),
        .fall_pulse (ext0_fall)
    );
    fall_edge_detect u_ext1 (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_in     (ext_irq1_pin),
        .enable     (port_function_select_b[irq_ctrl_pkg::BIT1]),
        .fall_pulse (ext1_fall)
    );

    // hardware set sources in priority order
    assign set_evt = {serial_done, conv_done, tmr_c_ovf, tmr_b_ovf, tmr_a_ovf,
                      ext1_fall, ext0_fall};
    assign eligible = flag_ff & ~mask_ff;

    // write decode: flags and masks sit at fixed bit slots
    always_comb begin
        wr_clear   = '0;
        wr_mask_en = '0;
        if (bit_wr) begin
            wr_clear[irq_ctrl_pkg::SRC_EXT0] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD0, irq_ctrl_pkg::BIT2);
            wr_mask_en[irq_ctrl_pkg::SRC_EXT0] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD0, irq_ctrl_pkg::BIT3);
            wr_clear[irq_ctrl_pkg::SRC_EXT1] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD1, irq_ctrl_pkg::BIT0);
            wr_mask_en[irq_ctrl_pkg::SRC_EXT1] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD1, irq_ctrl_pkg::BIT1);
            wr_clear[irq_ctrl_pkg::SRC_TMR_A] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD1, irq_ctrl_pkg::BIT2);
            wr_mask_en[irq_ctrl_pkg::SRC_TMR_A] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD1, irq_ctrl_pkg::BIT3);
            wr_clear[irq_ctrl_pkg::SRC_TMR_B] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD2, irq_ctrl_pkg::BIT0);
            wr_mask_en[irq_ctrl_pkg::SRC_TMR_B] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD2, irq_ctrl_pkg::BIT1);
            wr_clear[irq_ctrl_pkg::SRC_TMR_C] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD2, irq_ctrl_pkg::BIT2);
            wr_mask_en[irq_ctrl_pkg::SRC_TMR_C] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD2, irq_ctrl_pkg::BIT3);
            wr_clear[irq_ctrl_pkg::SRC_CONV] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD3, irq_ctrl_pkg::BIT0);
            wr_mask_en[irq_ctrl_pkg::SRC_CONV] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD3, irq_ctrl_pkg::BIT1);
            wr_clear[irq_ctrl_pkg::SRC_SERIAL] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD3, irq_ctrl_pkg::BIT2);
            wr_mask_en[irq_ctrl_pkg::SRC_SERIAL] =
                bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD3, irq_ctrl_pkg::BIT3);
            // a write of one to a flag is a no-op
            wr_clear = wr_clear & {7{~bit_wdata}};
        end
    end

    // fixed priority encoder, lowest index wins
    always_comb begin
        win_idx      = 3'h0;
        any_eligible = 1'b0;
        for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                win_idx      = 3'(i);
                any_eligible = 1'b1;
            end
        end
    end

    // accept only at an instruction boundary with enable set
    assign accept = any_eligible && ie_ff && instr_done && !stop_mode;

    // request flags per source; set wins over a same-cycle clear
    generate
        for (genvar g = 0; g < irq_ctrl_pkg::NUM_SRC; g++) begin : g_flag
            logic flag_bit_ff; // this source's request flag
            logic mask_bit_ff; // this source's mask
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_bit_ff <= irq_ctrl_pkg::FLAG_RST;
                end else if (stop_mode) begin
                    flag_bit_ff <= irq_ctrl_pkg::FLAG_RST;
                end else if (set_evt[g]) begin
                    flag_bit_ff <= 1'b1;
                end else if (wr_clear[g]) begin
                    flag_bit_ff <= 1'b0;
                end
            end
            // masks, set on reset and stop
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mask_bit_ff <= irq_ctrl_pkg::MASK_RST;
                end else if (stop_mode) begin
                    mask_bit_ff <= irq_ctrl_pkg::MASK_RST;
                end else if (wr_mask_en[g]) begin
                    mask_bit_ff <= bit_wdata;
                end
            end
            // each block owns its flops; the vectors are plain nets so no
            // variable is written from more than one process
            assign flag_ff[g] = flag_bit_ff;
            assign mask_ff[g] = mask_bit_ff;
        end
    endgenerate

    // global enable: cleared by accept, set by return, bit writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_ff <= irq_ctrl_pkg::ENABLE_RST;
        end else if (stop_mode) begin
            ie_ff <= irq_ctrl_pkg::ENABLE_RST;
        end else if (accept) begin
            ie_ff <= 1'b0;
        end else if (return_from_irq_instr) begin
            ie_ff <= 1'b1;
        end else if (bit_wr && bit_hit(bit_addr, bit_sel, irq_ctrl_pkg::ADDR_WORD0,
                                       irq_ctrl_pkg::BIT0)) begin
            ie_ff <= bit_wdata;
        end
    end
    assign global_irq_enable = ie_ff;

    // acceptance outputs to the sequencer, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_take     <= 1'b0;
            irq_vector   <= irq_ctrl_pkg::VEC_BASE;
            sp_decrement <= '0;
        end else begin
            irq_take     <= accept;
            if (accept) begin
                // vector base plus two per priority step
                irq_vector   <= irq_ctrl_pkg::VEC_BASE +
                                14'(irq_ctrl_pkg::VEC_STEP * win_idx);
                sp_decrement <= irq_ctrl_pkg::SP_DECREMENT;
            end else begin
                sp_decrement <= '0;
            end
        end
    end

    // port select: bits 1..0 cleared by stop; event and stop-clear selects
    // survive stop, only reset or a port select write returns them to i/o use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_function_select_b <= irq_ctrl_pkg::PORT_SEL_RST;
        end else if (port_sel_wr) begin
            port_function_select_b <= port_sel_wdata;
        end else if (stop_mode) begin
            port_function_select_b[irq_ctrl_pkg::BIT1:irq_ctrl_pkg::BIT0] <= '0;
        end
    end

    // routed pin synchronisers; stop-clear idles high (active low pin)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d2_sync_ff <= '0;
            d4_sync_ff <= 2'h3;
        end else begin
            d2_sync_ff <= {d2_sync_ff[0], port_d_bit2};
            d4_sync_ff <= {d4_sync_ff[0], port_d_bit4};
        end
    end

    // routed functions only follow the pin when selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_event_in <= 1'b0;
            stop_clear_in  <= 1'b1;
        end else begin
            timer_event_in <= port_function_select_b[irq_ctrl_pkg::BIT2] &
                              d2_sync_ff[1];
            stop_clear_in  <= ~port_function_select_b[irq_ctrl_pkg::BIT3] |
                              d4_sync_ff[1];
        end
    end

    // read mux of the four control words; enable reads back in bit 0
    always_comb begin
        nxt_rd = 4'h0;
        if (bit_addr == irq_ctrl_pkg::ADDR_WORD0) begin
            nxt_rd = {mask_ff[irq_ctrl_pkg::SRC_EXT0], flag_ff[irq_ctrl_pkg::SRC_EXT0],
                      1'b0, ie_ff};
        end else if (bit_addr == irq_ctrl_pkg::ADDR_WORD1) begin
            nxt_rd = {mask_ff[irq_ctrl_pkg::SRC_TMR_A], flag_ff[irq_ctrl_pkg::SRC_TMR_A],
                      mask_ff[irq_ctrl_pkg::SRC_EXT1], flag_ff[irq_ctrl_pkg::SRC_EXT1]};
        end else if (bit_addr == irq_ctrl_pkg::ADDR_WORD2) begin
            nxt_rd = {mask_ff[irq_ctrl_pkg::SRC_TMR_C], flag_ff[irq_ctrl_pkg::SRC_TMR_C],
                      mask_ff[irq_ctrl_pkg::SRC_TMR_B], flag_ff[irq_ctrl_pkg::SRC_TMR_B]};
        end else if (bit_addr == irq_ctrl_pkg::ADDR_WORD3) begin
            nxt_rd = {mask_ff[irq_ctrl_pkg::SRC_SERIAL], flag_ff[irq_ctrl_pkg::SRC_SERIAL],
                      mask_ff[irq_ctrl_pkg::SRC_CONV], flag_ff[irq_ctrl_pkg::SRC_CONV]};
        end
    end

    // read data registered; port select is write-only and reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word <= '0;
        end else begin
            rd_word <= nxt_rd;
        end
    end

    // checks
    chk_accept_clears_ie: assert property (@(posedge clk) disable iff (!rst_n)
        accept |=> !ie_ff) else $error("enable not cleared on accept");
    chk_accept_needs_ie: assert property (@(posedge clk) disable iff (!rst_n)
        irq_take |-> $past(ie_ff)) else $error("accept without enable");
    // a software clear of the winner in the accept cycle is legal, so it is left out;
    // the winner index is taken from the accept cycle, not the following one
    chk_flag_survives: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && !wr_clear[win_idx]) |=> flag_ff[$past(win_idx)])
        else $error("flag dropped on accept");
    chk_one_no_set: assert property (@(posedge clk) disable iff (!rst_n)
        (!flag_ff[irq_ctrl_pkg::SRC_EXT0] && !set_evt[irq_ctrl_pkg::SRC_EXT0] && !stop_mode)
        |=> !flag_ff[irq_ctrl_pkg::SRC_EXT0])
        else $error("flag set without event");
    // the winner must have been both pending and unmasked at the accept edge
    chk_mask_defers: assert property (@(posedge clk) disable iff (!rst_n)
        irq_take |-> $past(flag_ff[win_idx] && !mask_ff[win_idx]))
        else $error("masked request taken");
    chk_event_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (set_evt[irq_ctrl_pkg::SRC_TMR_B] && !stop_mode) |=> flag_ff[irq_ctrl_pkg::SRC_TMR_B])
        else $error("timer flag not set");
    chk_stop_clears: assert property (@(posedge clk) disable iff (!rst_n)
        stop_mode |=> (flag_ff == '0) && (mask_ff == '1) && !ie_ff)
        else $error("stop did not clear");
    chk_sp_four: assert property (@(posedge clk) disable iff (!rst_n)
        irq_take |-> sp_decrement == irq_ctrl_pkg::SP_DECREMENT)
        else $error("stack decrement wrong");
    chk_stop_keeps_sel3: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_mode && !port_sel_wr) |=> $stable(port_function_select_b[irq_ctrl_pkg::BIT3]))
        else $error("stop-clear select lost in stop");
    // event select is cleared by reset or a port select write, not by stop
    chk_stop_keeps_sel2: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_mode && !port_sel_wr) |=> $stable(port_function_select_b[irq_ctrl_pkg::BIT2]))
        else $error("event select lost in stop");
    // enable is gone after a take, so two takes can never be adjacent
    chk_take_single: assert property (@(posedge clk) disable iff (!rst_n)
        irq_take |=> !irq_take) else $error("accept repeated without enable");
    chk_return_sets_ie: assert property (@(posedge clk) disable iff (!rst_n)
        (return_from_irq_instr && !accept && !stop_mode) |=> ie_ff)
        else $error("return did not set enable");
    // routed functions must stay quiet while their pin is general i/o
    chk_event_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !port_function_select_b[irq_ctrl_pkg::BIT2] |=> !timer_event_in)
        else $error("event routed while deselected");
    chk_stop_clear_in_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !port_function_select_b[irq_ctrl_pkg::BIT3] |=> stop_clear_in)
        else $error("stop-clear routed while deselected");
    chk_edge_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !port_function_select_b[irq_ctrl_pkg::BIT0] |=> !ext0_fall)
        else $error("pin edge seen while deselected");
endmodule // interrupt_flag_mask_unit

// >>> verification/cpu_seq_model.sv
// instruction sequencer model that ends an instruction every other cycle
`timescale 1ns/100ps
module cpu_seq_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // accept side of the unit
    input  wire logic        irq_take,
    input  wire logic [13:0] irq_vector,
    input  wire logic [3:0]  sp_decrement,
    // sequencer side
    output logic             instr_done,
    output int               take_cnt,
    output logic [13:0]      last_vec,
    output int               bad_cnt
);
    logic prev_done;  // instruction end seen at the previous edge

    // two-cycle instructions, changed off the sampling edge
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= ~instr_done;
        end
    end

    // log every accept; a take not after an instruction end is an error
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_done <= 1'b0;
            take_cnt  <= 0;
            last_vec  <= 14'h0000;
            bad_cnt   <= 0;
        end else begin
            prev_done <= instr_done;
            if (irq_take === 1'b1) begin
                take_cnt <= take_cnt + 1;
                last_vec <= irq_vector;
                // push then stack pointer down by four
                if (prev_done !== 1'b1 || sp_decrement !== 4'h4) begin
                    bad_cnt <= bad_cnt + 1;
                end
            end
        end
    end
endmodule // cpu_seq_model

// >>> verification/interrupt_flag_mask_unit_bench.sv
// self-checking bench for the interrupt flag and mask unit
`timescale 1ns/100ps
module interrupt_flag_mask_unit_bench;
    logic        clk, rst_n, stop_mode, bit_wr, bit_wdata, port_sel_wr, ret;
    logic [5:0]  bit_addr;
    logic [1:0]  bit_sel;
    logic [3:0]  port_sel_wdata;
    logic [4:0]  ev;   // tmr_a, tmr_b, tmr_c, serial, conv
    logic        pin0, pin1, pd2, pd4;
    logic [3:0]  rd_word, sp_decrement, port_function_select_b;
    logic [13:0] irq_vector, last_vec;
    logic        irq_take, global_irq_enable, timer_event_in, stop_clear_in, instr_done;
    int          take_cnt, bad_cnt, failures, tests_run;
    // rows {word, flag bit, mask bit, vector}, tmr_a first
    localparam logic [49:0] ROWS = {10'h31c, 10'h3be, 10'h2ba, 10'h218, 10'h1b6};

    interrupt_flag_mask_unit DUT (.clk(clk), .rst_n(rst_n), .stop_mode(stop_mode),
        .bit_addr(bit_addr), .bit_sel(bit_sel), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
        .port_sel_wr(port_sel_wr), .port_sel_wdata(port_sel_wdata), .rd_word(rd_word),
        .instr_done(instr_done), .return_from_irq_instr(ret), .irq_take(irq_take),
        .irq_vector(irq_vector), .sp_decrement(sp_decrement),
        .global_irq_enable(global_irq_enable), .tmr_a_ovf(ev[0]), .tmr_b_ovf(ev[1]),
        .tmr_c_ovf(ev[2]), .serial_done(ev[3]), .conv_done(ev[4]), .ext_irq0_pin(pin0),
        .ext_irq1_pin(pin1), .port_d_bit2(pd2), .port_d_bit4(pd4),
        .timer_event_in(timer_event_in), .stop_clear_in(stop_clear_in),
        .port_function_select_b(port_function_select_b));
    cpu_seq_model seq (.clk(clk), .rst_n(rst_n), .irq_take(irq_take),
        .irq_vector(irq_vector), .sp_decrement(sp_decrement), .instr_done(instr_done),
        .take_cnt(take_cnt), .last_vec(last_vec), .bad_cnt(bad_cnt));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // single bit write, strobe held over one rising edge
    task automatic wr(input logic [5:0] a, input logic [1:0] s, input logic d);
        @(negedge clk) {bit_addr, bit_sel, bit_wdata, bit_wr} = {a, s, d, 1'b1};
        @(negedge clk) bit_wr = 1'b0;
    endtask

    // registered read appears one cycle after the address
    task automatic rd(input logic [5:0] a, input logic [3:0] e);
        @(negedge clk) bit_addr = a;
        @(negedge clk) check({10'h000, rd_word}, {10'h000, e});
    endtask

    task automatic psel(input logic [3:0] d);
        @(negedge clk) {port_sel_wdata, port_sel_wr} = {d, 1'b1};
        @(negedge clk) port_sel_wr = 1'b0;
    endtask

    // one-cycle event or return pulses
    task automatic pulse(input logic [4:0] p);
        @(negedge clk) ev = p;
        @(negedge clk) ev = 5'h00;
    endtask

    task automatic ret_pulse();
        @(negedge clk) ret = 1'b1;
        @(negedge clk) ret = 1'b0;
    endtask

    // bounded wait for the model to log an accept
    task automatic wait_take(input int e);
        for (int k = 0; k < 20 && take_cnt != e; k++) @(negedge clk);
        check(14'(take_cnt), 14'(e));
    endtask

    // pins idle high; a pin that is held needs several cycles to sync
    task automatic pin_hold(input logic p0, input logic p1);
        @(negedge clk) {pin0, pin1} = {p0, p1};
        repeat (8) @(negedge clk);
    endtask

    // watchdog, far longer than the sequence needs
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end

    initial begin
        logic [9:0] r;
        logic [5:0] a;
        int         n;
        {stop_mode, bit_wr, bit_wdata, port_sel_wr, ret, bit_sel} = '0;
        {bit_addr, port_sel_wdata, ev} = '0;
        {pin0, pin1, pd2, pd4} = 4'hf;
        failures = 0;
        tests_run = 0;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        // reset image: masks one, flags and enable zero
        for (int i = 0; i < 4; i++) rd(6'(i), (i == 0) ? 4'h8 : 4'ha);
        check({10'h000, port_function_select_b}, 14'h0000);
        check({13'h0000, stop_clear_in}, 14'h0001);
        // each internal source: set, defer, accept, keep, clear
        for (int i = 0; i < 5; i++) begin
            r = ROWS[i*10 +: 10];
            a = {4'h0, r[9:8]};
            n = take_cnt;
            pulse(5'h01 << i);
            rd(a, 4'ha | (4'h1 << r[7:6]));
            wr(6'h00, 2'h0, 1'b1);
            repeat (6) @(negedge clk);
            check(14'(take_cnt - n), 14'h0000);
            wr(a, r[5:4], 1'b0);
            wait_take(n + 1);
            check(last_vec, {10'h000, r[3:0]});
            check({13'h0000, global_irq_enable}, 14'h0000);
            rd(a, (4'ha & ~(4'h1 << r[5:4])) | (4'h1 << r[7:6]));
            wr(a, r[7:6], 1'b0);
            wr(a, r[7:6], 1'b1);
            wr(a, r[5:4], 1'b1);
            rd(a, 4'ha);
        end
        // timer b beats converter, return re-enables
        n = take_cnt;
        pulse(5'h12);
        wr(6'h02, 2'h1, 1'b0);
        wr(6'h03, 2'h1, 1'b0);
        wr(6'h00, 2'h0, 1'b1);
        wait_take(n + 1);
        check(last_vec, 14'h0008);
        ret_pulse();
        wait_take(n + 2);
        check(last_vec, 14'h0008);
        wr(6'h02, 2'h0, 1'b0);
        ret_pulse();
        wait_take(n + 3);
        check(last_vec, 14'h000c);
        check(14'(bad_cnt), 14'h0000);
        wr(6'h03, 2'h0, 1'b0);
        wr(6'h02, 2'h1, 1'b1);
        wr(6'h03, 2'h1, 1'b1);
        // pin edges ignored while routed to general io
        pin_hold(1'b0, 1'b1);
        pin_hold(1'b1, 1'b1);
        rd(6'h00, 4'h8);
        psel(4'hf);
        check({10'h000, port_function_select_b}, 14'h000f);
        pin_hold(1'b0, 1'b1);
        rd(6'h00, 4'hc);
        wr(6'h00, 2'h2, 1'b0);
        pin_hold(1'b1, 1'b1);
        rd(6'h00, 4'h8);
        pin_hold(1'b1, 1'b0);
        rd(6'h01, 4'hb);
        // both pins pending: first pin wins and keeps its flag, return takes the second
        n = take_cnt;
        pin_hold(1'b0, 1'b0);
        wr(6'h01, 2'h1, 1'b0);
        wr(6'h00, 2'h3, 1'b0);
        wr(6'h00, 2'h0, 1'b1);
        wait_take(n + 1);
        check(last_vec, 14'h0002);
        rd(6'h00, 4'h4);
        wr(6'h00, 2'h2, 1'b0);
        ret_pulse();
        wait_take(n + 2);
        check(last_vec, 14'h0004);
        wr(6'h01, 2'h1, 1'b1);
        wr(6'h00, 2'h3, 1'b1);
        @(negedge clk) {pd2, pd4} = 2'b10;
        repeat (6) @(negedge clk);
        check({13'h0000, timer_event_in}, 14'h0001);
        check({13'h0000, stop_clear_in}, 14'h0000);
        @(negedge clk) pd2 = 1'b0;
        repeat (6) @(negedge clk);
        check({13'h0000, timer_event_in}, 14'h0000);
        // stop mode clears enable, flags, two pin selects; event and stop-clear kept
        wr(6'h00, 2'h0, 1'b1);
        @(negedge clk) stop_mode = 1'b1;
        repeat (2) @(negedge clk);
        stop_mode = 1'b0;
        check({12'h000, port_function_select_b[1:0]}, 14'h0000);
        check({13'h0000, port_function_select_b[2]}, 14'h0001);
        check({13'h0000, port_function_select_b[3]}, 14'h0001);
        rd(6'h01, 4'ha);
        rd(6'h00, 4'h8);
        // second reset in mid-run, enable set beforehand
        wr(6'h00, 2'h0, 1'b1);
        @(negedge clk) rst_n = 1'b0;
        @(negedge clk);
        check({10'h000, port_function_select_b}, 14'h0000);
        check({12'h000, timer_event_in, stop_clear_in}, 14'h0001);
        rst_n = 1'b1;
        rd(6'h00, 4'h8);
        check({13'h0000, irq_take}, 14'h0000);
        report_and_stop();
    end
endmodule // interrupt_flag_mask_unit_bench
